// file: rtl/sbrs_pkg.sv
// shared types and constants for the register read and self-test disable command decoder
package sbrs_pkg;

	typedef enum logic [1:0] {
		SBRS_FMT_STD_LONG = 2'h0,
		SBRS_FMT_STD_SHORT = 2'h1,
		SBRS_FMT_ENH_LONG = 2'h2,
		SBRS_FMT_ENH_SHORT = 2'h3
	} sbrs_fmt_t;

	typedef enum logic [1:0] {
		SBRS_PEND_NONE = 2'h0,
		SBRS_PEND_READ = 2'h1,
		SBRS_PEND_STATUS = 2'h2
	} sbrs_pend_t;

	// decoded frame from the bus receiver, crc already checked
	typedef struct packed {
		sbrs_fmt_t fmt;
		logic crc_ok;
		logic [7:0] data;
		logic [3:0] addr;
		logic [3:0] cmd;
	} sbrs_frame_t;

	typedef struct packed {
		logic is_long;
		logic [15:0] data;
	} sbrs_resp_t;

	localparam logic [3:0] SBRS_CMD_REG_READ = 4'hB;
	localparam logic [3:0] SBRS_CMD_SELFTEST_OFF = 4'hC;
	localparam logic [3:0] SBRS_CMD_SELFTEST_ON = 4'hD;
	localparam logic [3:0] SBRS_GLOBAL_ADDR = 4'h0;

	// status byte field positions
	localparam int SBRS_ST_OTP = 7;
	localparam int SBRS_ST_UV = 6;
	localparam int SBRS_ST_ACTIVE = 5;
	localparam int SBRS_ST_PASS = 4;
	localparam int SBRS_ST_ATTR_LO = 2;
	localparam int SBRS_ST_ERR = 1;

	// software registers
	localparam logic [3:0] SBRS_REG_CTRL = 4'h0;
	localparam logic [3:0] SBRS_REG_STATUS = 4'h4;
	localparam int SBRS_CTRL_CLR_LOCK = 0;
	localparam int SBRS_CTRL_NO_SELFTEST = 1;
	localparam logic [7:0] SBRS_CTRL_RESET = 8'h00;

	localparam int SBRS_SYNC_STAGES = 3;

endpackage : sbrs_pkg

// file: rtl/sbrs_cmd.sv
// command decoder for register read, self-test disable/enable and self-test lockout
// Notes on behaviour
// - register read only in long frame formats
// - register read to global address is ignored
// - register read command code is 1011
// - foreign device address discards the command
// - read reply: address, byte address, register data
// - self-test disable accepted in all four formats
// - disable data bits only feed the crc
// - global disable executes but sends no reply
// - self-test disable command code is 1100
// - disable removes self-test stimulus from transducer
// - short reply: zeros then status byte
// - long reply: address, zero nibble, status byte
// - error flag mirrors internal device error
// - active flag mirrors self-test circuitry state
// - pass switch state reported in reply
// - reserve voltage low flag follows cap comparator
// - otp flag shows programming enable
// - attribute bits copied from config register
// - two consecutive disables enter lockout
// - lockout ends only on listed clear events
// - lockout refuses enable, reports active cleared
// - self-test enable command code is 1101
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module sbrs_cmd
	import sbrs_pkg::*;
#(
	parameter int REG_AW = 4,
	parameter int REG_DW = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [3:0] dev_addr,
	input wire logic frame_valid,
	input wire sbrs_frame_t frame,
	output logic [3:0] reg_byte_addr,
	input wire logic [7:0] reg_rd_data,
	input wire logic otp_prog_enabled_flag,
	input wire logic pass_switch_state,
	input wire logic [1:0] attribute_bits,
	input wire logic internal_error,
	input wire logic reserve_cap_pin_low,
	input wire logic clear_cmd,
	input wire logic reg_uv_reset,
	input wire logic frame_timeout_reset,
	output logic resp_valid,
	output sbrs_resp_t resp,
	output logic selftest_drive,
	output logic lockout,
	input wire logic [REG_AW-1:0] bus_addr,
	input wire logic [REG_DW-1:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [REG_DW-1:0] bus_rdata
);

	if (REG_AW < 3 || REG_DW < 8) begin : g_bad_param
		$error("sbrs_cmd: bus address must be 3 bits or more and data 8 bits or more");
	end

	function automatic logic fmt_long(input sbrs_fmt_t f);
		fmt_long = (f == SBRS_FMT_STD_LONG) || (f == SBRS_FMT_ENH_LONG);
	endfunction : fmt_long

	function automatic logic [REG_AW-1:0] reg_off(input logic [3:0] o);
		reg_off = REG_AW'(o);
	endfunction : reg_off

	logic [SBRS_SYNC_STAGES-1:0] uv_sync_r;
	logic uv_r;
	logic [7:0] ctrl_r;
	logic last_off_r;
	logic lockout_r;
	logic selftest_r;
	logic [3:0] reg_byte_addr_r;
	sbrs_pend_t pend_r;
	logic pend_long_r;
	logic resp_valid_r;
	sbrs_resp_t resp_r;
	logic [REG_DW-1:0] bus_rdata_r;

	logic good;
	logic own;
	logic glob;
	logic acc_read;
	logic acc_off;
	logic acc_on;
	logic any_own;
	logic lock_clear;
	logic [7:0] status_byte;

	// a frame counts only with good crc; the disable data byte is not looked at
	assign good = frame_valid && frame.crc_ok;
	assign own = frame.addr == dev_addr && frame.addr != SBRS_GLOBAL_ADDR;
	assign glob = frame.addr == SBRS_GLOBAL_ADDR;
	assign acc_read = good && own && frame.cmd == SBRS_CMD_REG_READ
		&& fmt_long(frame.fmt);
	assign acc_off = good && (own || glob) && frame.cmd == SBRS_CMD_SELFTEST_OFF;
	assign acc_on = good && own && frame.cmd == SBRS_CMD_SELFTEST_ON;
	assign any_own = good && own;
	assign lock_clear = uv_r || clear_cmd || reg_uv_reset || frame_timeout_reset
		|| (bus_wr && bus_addr == reg_off(SBRS_REG_CTRL) && bus_wdata[SBRS_CTRL_CLR_LOCK]);

	// the cap comparator is asynchronous; the level moves only when stages two and three agree
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			uv_sync_r <= '0;
		end else begin
			uv_sync_r <= {uv_sync_r[SBRS_SYNC_STAGES-2:0], reserve_cap_pin_low};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			uv_r <= 1'b0;
		end else if (uv_sync_r[1] == uv_sync_r[2]) begin
			uv_r <= uv_sync_r[2];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= SBRS_CTRL_RESET;
		end else if (bus_wr && bus_addr == reg_off(SBRS_REG_CTRL)) begin
			// the clear bit is a strobe and never stays set
			ctrl_r <= {bus_wdata[7:1], 1'b0};
		end
	end

	// a global disable counts too: it is carried out like an addressed one
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			last_off_r <= 1'b0;
		end else if (acc_off) begin
			last_off_r <= 1'b1;
		end else if (any_own) begin
			last_off_r <= 1'b0;
		end
	end

	// setting wins over a clear that lands in the same cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lockout_r <= 1'b0;
		end else if (acc_off && last_off_r) begin
			lockout_r <= 1'b1;
		end else if (lock_clear) begin
			lockout_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			selftest_r <= 1'b0;
		end else if (acc_off || lockout_r || ctrl_r[SBRS_CTRL_NO_SELFTEST]) begin
			selftest_r <= 1'b0;
		end else if (acc_on) begin
			selftest_r <= 1'b1;
		end
	end

	// first stage: steer the register map address and note what kind of reply is owed
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_byte_addr_r <= 4'h0;
			pend_r <= SBRS_PEND_NONE;
			pend_long_r <= 1'b0;
		end else begin
			pend_long_r <= fmt_long(frame.fmt);
			if (acc_read) begin
				reg_byte_addr_r <= frame.data[3:0];
				pend_r <= SBRS_PEND_READ;
			end else if ((acc_off && !glob) || acc_on) begin
				pend_r <= SBRS_PEND_STATUS;
			end else begin
				pend_r <= SBRS_PEND_NONE;
			end
		end
	end

	always_comb begin
		status_byte = 8'h00;
		status_byte[SBRS_ST_OTP] = otp_prog_enabled_flag;
		status_byte[SBRS_ST_UV] = uv_r;
		status_byte[SBRS_ST_ACTIVE] = selftest_r;
		status_byte[SBRS_ST_PASS] = pass_switch_state;
		status_byte[SBRS_ST_ATTR_LO +: 2] = attribute_bits;
		status_byte[SBRS_ST_ERR] = internal_error;
	end

	// second stage: the register map answers within the cycle, so the reply lands one edge later
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			resp_valid_r <= 1'b0;
			resp_r <= '0;
		end else begin
			case (pend_r)
				SBRS_PEND_READ: begin
					resp_valid_r <= 1'b1;
					resp_r <= {1'b1, dev_addr, reg_byte_addr_r, reg_rd_data};
				end
				SBRS_PEND_STATUS: begin
					resp_valid_r <= 1'b1;
					if (pend_long_r) begin
						resp_r <= {1'b1, dev_addr, 4'h0, status_byte};
					end else begin
						resp_r <= {1'b0, 8'h00, status_byte};
					end
				end
				default: begin
					resp_valid_r <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata_r <= '0;
		end else if (bus_rd) begin
			case (bus_addr)
				reg_off(SBRS_REG_CTRL): bus_rdata_r <= REG_DW'(ctrl_r);
				reg_off(SBRS_REG_STATUS): bus_rdata_r <= REG_DW'({uv_r, last_off_r,
					lockout_r, selftest_r});
				default: bus_rdata_r <= '0;
			endcase
		end
	end

	assign reg_byte_addr = reg_byte_addr_r;
	assign resp_valid = resp_valid_r;
	assign resp = resp_r;
	assign selftest_drive = selftest_r;
	assign lockout = lockout_r;
	assign bus_rdata = bus_rdata_r;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	logic resp_cause;
	assign resp_cause = acc_read || (acc_off && !glob) || acc_on;

	sequence s_read_req;
		acc_read;
	endsequence

	sequence s_read_reply;
		resp_valid && resp.is_long && resp.data[11:8] == $past(frame.data[3:0], 2)
			&& resp.data[15:12] == dev_addr;
	endsequence

	sequence s_second_off;
		acc_off && last_off_r;
	endsequence

	a_read_reply_shape: assert property (s_read_req |-> ##2 s_read_reply)
		else $error("read reply missing or malformed");

	a_reply_has_cause: assert property (resp_valid |-> $past(resp_cause, 2))
		else $error("reply without an accepted command");

	a_global_off_quiet: assert property (acc_off && glob |-> ##2 !resp_valid)
		else $error("global disable answered");

	a_off_drops_drive: assert property (acc_off |=> !selftest_drive)
		else $error("stimulus still on after disable");

	a_two_offs_lock: assert property (s_second_off |=> lockout)
		else $error("two disables did not lock");

	a_lock_blocks_on: assert property (lockout && acc_on |=> !selftest_drive
		##1 (resp_valid && !resp.data[SBRS_ST_ACTIVE]))
		else $error("enable honoured under lockout");

	a_short_top_zero: assert property (resp_valid && !resp.is_long |->
		resp.data[15:8] == 8'h00 && !resp.data[0])
		else $error("short reply upper bits not zero");

	a_lock_holds: assert property (lockout && !lock_clear |=> lockout)
		else $error("lockout dropped without cause");

	a_read_addr_out: assert property (acc_read |=> reg_byte_addr == $past(frame.data[3:0]))
		else $error("register byte address not steered");

	a_foreign_quiet: assert property (good && !own && !glob |=>
		$stable(selftest_drive) && $stable(lockout))
		else $error("foreign address changed state");

	sequence s_status_long_req;
		resp_cause && !acc_read && fmt_long(frame.fmt);
	endsequence

	sequence s_status_long_reply;
		resp_valid && resp.is_long && resp.data[15:12] == dev_addr && resp.data[11:8] == 4'h0;
	endsequence

	sequence s_status_short_req;
		resp_cause && !acc_read && !fmt_long(frame.fmt);
	endsequence

	sequence s_status_short_reply;
		resp_valid && !resp.is_long && resp.data[15:8] == 8'h00;
	endsequence

	a_short_read_quiet: assert property (good && own && frame.cmd == SBRS_CMD_REG_READ
		&& !fmt_long(frame.fmt) |-> ##2 !resp_valid)
		else $error("read in short format answered");

	a_global_read_quiet: assert property (good && glob && frame.cmd == SBRS_CMD_REG_READ
		|-> ##2 !resp_valid)
		else $error("read to global address answered");

	a_foreign_no_reply: assert property (good && !own && !glob
		|-> ##2 !resp_valid)
		else $error("foreign address answered");

	a_bad_crc_quiet: assert property (frame_valid && !frame.crc_ok
		|-> ##2 !resp_valid)
		else $error("frame with failed check answered");

	a_read_reply_data: assert property (s_read_req
		|-> ##2 resp.data[7:0] == $past(reg_rd_data))
		else $error("read reply data not the register content");

	a_long_status_shape: assert property (s_status_long_req
		|-> ##2 s_status_long_reply)
		else $error("long status reply malformed");

	a_short_status_shape: assert property (s_status_short_req
		|-> ##2 s_status_short_reply)
		else $error("short status reply malformed");

	a_err_flag_copy: assert property (pend_r == SBRS_PEND_STATUS
		|=> resp.data[SBRS_ST_ERR] == $past(internal_error))
		else $error("error flag not reported");

	a_active_flag_copy: assert property (pend_r == SBRS_PEND_STATUS
		|=> resp.data[SBRS_ST_ACTIVE] == $past(selftest_drive))
		else $error("active flag not reported");

	a_pass_flag_copy: assert property (pend_r == SBRS_PEND_STATUS
		|=> resp.data[SBRS_ST_PASS] == $past(pass_switch_state))
		else $error("pass switch state not reported");

	a_uv_flag_copy: assert property (pend_r == SBRS_PEND_STATUS
		|=> resp.data[SBRS_ST_UV] == $past(uv_r))
		else $error("reserve voltage flag not reported");

	a_otp_flag_copy: assert property (pend_r == SBRS_PEND_STATUS
		|=> resp.data[SBRS_ST_OTP] == $past(otp_prog_enabled_flag))
		else $error("otp flag not reported");

	a_attr_bits_copy: assert property (pend_r == SBRS_PEND_STATUS
		|=> resp.data[SBRS_ST_ATTR_LO +: 2] == $past(attribute_bits))
		else $error("attribute bits not reported");

	a_uv_sync_rise: assert property (reserve_cap_pin_low [*4] |=> uv_r)
		else $error("reserve voltage low not flagged");

	a_uv_sync_fall: assert property (!reserve_cap_pin_low [*4] |=> !uv_r)
		else $error("reserve voltage flag stuck");

	a_on_sets_drive: assert property (acc_on && !lockout
		&& !ctrl_r[SBRS_CTRL_NO_SELFTEST] |=> selftest_drive)
		else $error("enable did not start self-test");

	a_lock_no_drive: assert property (lockout |=> !selftest_drive)
		else $error("self-test on under lockout");

	a_clear_ends_lock: assert property (lock_clear && !(acc_off && last_off_r)
		|=> !lockout)
		else $error("lockout kept after a clear event");

	a_ctrl_blocks_on: assert property (ctrl_r[SBRS_CTRL_NO_SELFTEST]
		|=> !selftest_drive)
		else $error("self-test on while held off");

	a_other_breaks_run: assert property (any_own && !acc_off |=> !last_off_r)
		else $error("other command kept the disable run");

	a_global_off_counts: assert property (acc_off && glob |=> last_off_r)
		else $error("global disable not counted");

	a_status_read_lock: assert property (bus_rd && bus_addr == reg_off(SBRS_REG_STATUS)
		|=> bus_rdata[1] == $past(lockout))
		else $error("status register lockout bit wrong");

endmodule : sbrs_cmd

`default_nettype wire

// file: bench/sbrs_master_model.sv
// bus master stand-in: sends decoded frames and serves the register map
`timescale 1ns/1ns
`default_nettype none
module sbrs_master_model
	import sbrs_pkg::*;
(
	input wire logic clock,
	input wire logic [3:0] reg_byte_addr,
	output logic [7:0] reg_rd_data,
	output logic frame_valid,
	output sbrs_frame_t frame
);
	// distinct content per byte address so a wrong echo shows
	assign reg_rd_data = {~reg_byte_addr, reg_byte_addr};
	// the bench sets this to send a frame whose check failed
	logic crc_bad = 1'b0;
	initial begin
		frame_valid = 1'b0;
		frame = '0;
	end
	task automatic send(input sbrs_fmt_t fmt, input logic [3:0] addr, input logic [3:0] cmd,
		input logic [7:0] data);
		sbrs_frame_t f;
		f.fmt = fmt;
		f.crc_ok = !crc_bad;
		f.addr = addr;
		f.cmd = cmd;
		f.data = (cmd == SBRS_CMD_REG_READ) ? {4'h0, data[3:0]} : data;
		@(posedge clock);
		frame_valid <= 1'b1;
		frame <= f;
		@(posedge clock);
		frame_valid <= 1'b0;
		// released lines flip so stale fields never look valid
		frame <= ~f;
	endtask : send
endmodule : sbrs_master_model
`default_nettype wire

// file: bench/test_sensor_bus_regread_selftest_off.sv
// self-checking bench for the read and self-test disable command decoder
`timescale 1ns/1ns
`default_nettype none
module test_sensor_bus_regread_selftest_off
	import sbrs_pkg::*;
;
	localparam logic [3:0] DEV = 4'h5;
	localparam logic [16:0] NONE = 17'h0FFFF;
	logic clock, rst_n, frame_valid, otp, pass, err, uv, clr, ruv, fto, bus_wr, bus_rd;
	logic resp_valid, selftest_drive, lockout;
	logic [1:0] attr;
	logic [3:0] rba, bus_addr, ra;
	logic [7:0] rrd, bus_wdata, bus_rdata;
	sbrs_frame_t frame;
	sbrs_resp_t resp;
	sbrs_fmt_t fmt;
	int n_mismatch = 0;
	int samples_checked = 0;
	sbrs_master_model i_master (.clock(clock), .reg_byte_addr(rba), .reg_rd_data(rrd),
		.frame_valid(frame_valid), .frame(frame));
	sbrs_cmd i_dut (.clock(clock), .rst_n(rst_n), .dev_addr(DEV), .frame_valid(frame_valid),
		.frame(frame), .reg_byte_addr(rba), .reg_rd_data(rrd), .otp_prog_enabled_flag(otp),
		.pass_switch_state(pass), .attribute_bits(attr), .internal_error(err),
		.reserve_cap_pin_low(uv), .clear_cmd(clr), .reg_uv_reset(ruv),
		.frame_timeout_reset(fto), .resp_valid(resp_valid), .resp(resp),
		.selftest_drive(selftest_drive), .lockout(lockout), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	function automatic logic [16:0] rep(input sbrs_fmt_t f, input logic act);
		logic [7:0] st;
		st = {otp, uv, act, pass, attr, err, 1'b0};
		return f[0] ? {9'h000, st} : {1'b1, DEV, 4'h0, st};
	endfunction : rep
	task automatic check_resp(input logic [16:0] exp, input logic [16:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value reply expected %h seen %h", exp, got);
		end
	endtask : check_resp
	task automatic check_level(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check_level
	task automatic cmd(input sbrs_fmt_t f, input logic [3:0] a, input logic [3:0] c,
		input logic [7:0] d, input logic [16:0] exp);
		logic [16:0] got;
		got = NONE;
		i_master.send(f, a, c, d);
		repeat (4) begin
			@(posedge clock);
			#1;
			if (resp_valid === 1'b1) got = resp;
		end
		check_resp(exp, got);
	endtask : cmd
	task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clock);
		bus_wr <= 1'b0;
	endtask : bus_write
	task automatic bus_read(input string name, input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clock);
		bus_rd <= 1'b0;
		#1;
		check_level(name, exp, bus_rdata);
	endtask : bus_read
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#100000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		{rst_n, otp, pass, err, uv, clr, ruv, fto, bus_wr, bus_rd, attr} = '0;
		bus_addr = 4'h0;
		bus_wdata = 8'h00;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		bus_read("status", SBRS_REG_STATUS, 8'h00);
		bus_read("ctrl", SBRS_REG_CTRL, SBRS_CTRL_RESET);
		bus_write(SBRS_REG_CTRL, 8'hF8);
		bus_read("ctrl", SBRS_REG_CTRL, 8'hF8);
		bus_read("unmapped", 4'h7, 8'h00);
		for (int p = 0; p < 2; p++) begin
			@(posedge clock);
			{otp, pass, attr, err} <= p[0] ? 5'h0A : 5'h15;
			// expected replies read these inputs, so let the update land first
			#1;
			for (int f = 0; f < 4; f++) begin
				fmt = sbrs_fmt_t'(f[1:0]);
				ra = {p[0], f[1:0], ~p[0]};
				cmd(fmt, DEV, SBRS_CMD_SELFTEST_ON, 8'h3C, rep(fmt, 1'b1));
				check_level("drive", 8'h01, selftest_drive);
				cmd(fmt, DEV, SBRS_CMD_SELFTEST_OFF, {p[0], ra, 3'h5}, rep(fmt, 1'b0));
				check_level("drive", 8'h00, selftest_drive);
				cmd(fmt, DEV, SBRS_CMD_REG_READ, {4'hA, ra}, fmt[0] ? NONE : {1'b1, DEV, ra, ~ra, ra});
				check_level("lockout", 8'h00, lockout);
			end
		end
		cmd(SBRS_FMT_STD_LONG, 4'h0, SBRS_CMD_REG_READ, 8'h01, NONE);
		cmd(SBRS_FMT_STD_LONG, 4'h6, SBRS_CMD_REG_READ, 8'h01, NONE);
		cmd(SBRS_FMT_STD_LONG, 4'h6, SBRS_CMD_SELFTEST_ON, 8'h00, NONE);
		check_level("drive", 8'h00, selftest_drive);
		i_master.crc_bad = 1'b1;
		cmd(SBRS_FMT_STD_LONG, DEV, SBRS_CMD_SELFTEST_ON, 8'h00, NONE);
		i_master.crc_bad = 1'b0;
		check_level("drive", 8'h00, selftest_drive);
		fmt = SBRS_FMT_STD_LONG;
		cmd(fmt, DEV, SBRS_CMD_SELFTEST_OFF, 8'h00, rep(fmt, 1'b0));
		cmd(fmt, DEV, 4'h3, 8'h00, NONE);
		cmd(fmt, DEV, SBRS_CMD_SELFTEST_OFF, 8'h00, rep(fmt, 1'b0));
		check_level("lockout", 8'h00, lockout);
		bus_write(SBRS_REG_CTRL, 8'h02);
		cmd(fmt, DEV, SBRS_CMD_SELFTEST_ON, 8'h00, rep(fmt, 1'b0));
		check_level("drive", 8'h00, selftest_drive);
		bus_write(SBRS_REG_CTRL, 8'h00);
		for (int k = 0; k < 5; k++) begin
			cmd(SBRS_FMT_STD_LONG, DEV, SBRS_CMD_SELFTEST_ON, 8'h00, rep(SBRS_FMT_STD_LONG, 1'b1));
			cmd(SBRS_FMT_STD_SHORT, 4'h0, SBRS_CMD_SELFTEST_OFF, 8'hFF, NONE);
			check_level("drive", 8'h00, selftest_drive);
			cmd(SBRS_FMT_STD_LONG, DEV, SBRS_CMD_SELFTEST_OFF, 8'h00, rep(SBRS_FMT_STD_LONG, 1'b0));
			check_level("lockout", 8'h01, lockout);
			bus_read("status", SBRS_REG_STATUS, 8'h06);
			cmd(SBRS_FMT_STD_LONG, DEV, SBRS_CMD_SELFTEST_ON, 8'h00, rep(SBRS_FMT_STD_LONG, 1'b0));
			check_level("drive", 8'h00, selftest_drive);
			check_level("lockout", 8'h01, lockout);
			@(posedge clock);
			case (k)
				0: clr <= 1'b1;
				1: ruv <= 1'b1;
				2: fto <= 1'b1;
				3: bus_write(SBRS_REG_CTRL, 8'h01);
				default: uv <= 1'b1;
			endcase
			@(posedge clock);
			{clr, ruv, fto} <= 3'h0;
			// the comparator path is synchronised, so give it a few edges
			repeat (5) @(posedge clock);
			#1;
			check_level("lockout", 8'h00, lockout);
		end
		bus_read("status", SBRS_REG_STATUS, 8'h08);
		cmd(SBRS_FMT_STD_SHORT, DEV, SBRS_CMD_SELFTEST_OFF, 8'h00, rep(SBRS_FMT_STD_SHORT, 1'b0));
		tally_and_finish();
	end
endmodule : test_sensor_bus_regread_selftest_off
`default_nettype wire
